// file: rtl/nes_map.svh
`ifndef NES_MAP_SVH
`define NES_MAP_SVH
// ==========================================
// Register offsets of the controller.
`define NES_REG_CTRL 4'h0
`define NES_REG_ADDR 4'h4
`define NES_REG_STAT 4'h8
`define NES_REG_DATA 4'hC
// ==========================================
// Control register fields.
`define NES_CTL_BYP 4
`define NES_CTL_VHH_ON 5
`define NES_CTL_UNPROT 6
`define NES_CTL_VHH_OFF 7
// ==========================================
// Operation codes written to the control register.
`define NES_OP_NONE 4'h0
`define NES_OP_CHIP 4'h1
`define NES_OP_BLOCK 4'h2
`define NES_OP_ADD 4'h3
`define NES_OP_SUSP 4'h4
`define NES_OP_RESUME 4'h5
`define NES_OP_RDRST 4'h6
`define NES_OP_HWRST 4'h7
`define NES_OP_POLL 4'h8
// ==========================================
// Device command codes and status bit positions.
`define NES_CMD_SETUP 8'h80
`define NES_CMD_CHIP 8'h10
`define NES_CMD_BLOCK 8'h30
`define NES_CMD_RESUME 8'h30
`define NES_CMD_SUSP 8'hB0
`define NES_CMD_RDRST 8'hF0
`define NES_BIT_POLL 7
`define NES_BIT_TOGGLE 6
`define NES_BIT_TIMER 3
// ==========================================
// Bus timing, in ns, and derived cycle counts.
`define NES_CLK_NS 5
`define NES_T_WE_NS 35
`define NES_T_RD_NS 100
`define NES_T_REC_NS 30
`define NES_T_RST_NS 500
`define NES_WE_CYC ((`NES_T_WE_NS + `NES_CLK_NS - 1) / `NES_CLK_NS)
`define NES_RD_CYC ((`NES_T_RD_NS + `NES_CLK_NS - 1) / `NES_CLK_NS)
`define NES_REC_CYC ((`NES_T_REC_NS + `NES_CLK_NS - 1) / `NES_CLK_NS)
`define NES_RST_CYC ((`NES_T_RST_NS + `NES_CLK_NS - 1) / `NES_CLK_NS)
`define NES_POLL_LIMIT 1000000
`endif

// file: rtl/nes_pkg.sv
`default_nettype none
package nes_pkg;
    typedef logic [3:0] nes_op_t;
    typedef enum logic [1:0] {BS_IDLE, BS_ACT, BS_REC} nes_bus_st_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_SEQ, ST_SEQW, ST_CHK, ST_CHKW,
        ST_P1, ST_P1W, ST_P2, ST_P2W, ST_HWR
    } nes_st_t;
endpackage
`default_nettype wire

// file: rtl/nes_bus_cycle.sv
`include "nes_map.svh"
`default_nettype none
module nes_bus_cycle
    import nes_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DQ_W = 16
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Cycle request.
    input wire logic start,
    input wire logic isWrite,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [DQ_W-1:0] dataIn,
    output logic done,
    output logic [DQ_W-1:0] readData,
    // Flash pins.
    output logic [ADDR_W-1:0] flashAddr,
    output logic [DQ_W-1:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [DQ_W-1:0] flashDqIn,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN
);
    nes_bus_st_t st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DQ_W-1:0] dq_r, dq_nxt, rd_r, rd_nxt, sync1_r, sync2_r;
    logic ce_r, ce_nxt, we_r, we_nxt, oe_r, oe_nxt, drv_r, drv_nxt;

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        dq_nxt = dq_r;
        rd_nxt = rd_r;
        ce_nxt = ce_r;
        we_nxt = we_r;
        oe_nxt = oe_r;
        drv_nxt = drv_r;
        case (st_r)
            BS_IDLE:
            begin
                if (start)
                begin
                    st_nxt = BS_ACT;
                    addr_nxt = addrIn;
                    dq_nxt = dataIn;
                    ce_nxt = 1'b1;
                    we_nxt = isWrite;
                    oe_nxt = !isWrite;
                    drv_nxt = isWrite;
                    cnt_nxt = isWrite ? 8'(`NES_WE_CYC) : 8'(`NES_RD_CYC);
                end
            end
            BS_ACT:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    // The read path is two flops late, so the read time covers it.
                    if (oe_r)
                        rd_nxt = sync2_r;
                    we_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    cnt_nxt = 8'(`NES_REC_CYC);
                    st_nxt = BS_REC;
                end
            end
            BS_REC:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    ce_nxt = 1'b0;
                    drv_nxt = 1'b0;
                    st_nxt = BS_IDLE;
                end
            end
            default:
                st_nxt = BS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        sync1_r <= flashDqIn;
        sync2_r <= sync1_r;
        if (rst)
        begin
            st_r <= BS_IDLE;
            cnt_r <= 8'h00;
            addr_r <= '0;
            dq_r <= '0;
            rd_r <= '0;
            ce_r <= 1'b0;
            we_r <= 1'b0;
            oe_r <= 1'b0;
            drv_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            dq_r <= dq_nxt;
            rd_r <= rd_nxt;
            ce_r <= ce_nxt;
            we_r <= we_nxt;
            oe_r <= oe_nxt;
            drv_r <= drv_nxt;
        end
    end

    assign done = (st_r == BS_REC) && (cnt_r == 8'h01);
    assign readData = rd_r;
    assign flashAddr = addr_r;
    assign flashDqOut = dq_r;
    assign flashDqOe = drv_r;
    assign flashCeN = !ce_r;
    assign flashWeN = !we_r;
    assign flashOeN = !oe_r;
endmodule // nes_bus_cycle
`default_nettype wire

// file: rtl/nes_host.sv
// What this block does
// RULE1: Resume command continues suspended program.
// RULE2: Repeat resumes ignored; new suspend allowed.
// RULE3: Follow progress via polling or toggle bit.
// RULE4: High voltage forces device into bypass.
// RULE5: Drop high voltage after operation completes.
// RULE6: Unprotect blocks before raising high voltage.
// RULE7: Chip erase is six writes, last starts.
// RULE8: Chip erase skips protected blocks silently.
// RULE9: Chip erase ignores commands, reads poll.
// RULE10: Failure needs read/reset to leave polling.
// RULE11: Chip erase sets unprotected bits to one.
// RULE12: Hardware reset aborts chip erase.
// RULE13: Bypass chip erase takes two writes.
// RULE14: Block erase six writes; repeat adds.
// RULE15: Each added block restarts the timeout.
// RULE16: Other command in timeout returns read.
// RULE17: Erase timer flag shows timeout expiry.
// RULE18: No block additions after erase starts.
// RULE19: Reads return polling after sixth write.
// RULE20: Block erase skips protected blocks silently.
// RULE21: Block erase takes only suspend, reset.
// RULE22: Bypass block erase two writes; repeat adds.
// RULE23: Suspend command interrupts running program.
// RULE24: Suspend in timeout ends it at once.
// RULE25: Malformed sequences return to read mode.
//
// The register addresses and the strobed register port are this design's own decisions.
`include "nes_map.svh"
`default_nettype none
module nes_host
    import nes_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DQ_W = 16,
    parameter int POLL_LIMIT = `NES_POLL_LIMIT,
    // Unlock cycle addresses and data; defaults are arbitrary.
    parameter logic [ADDR_W-1:0] UNL_ADDR1 = '0,
    parameter logic [ADDR_W-1:0] UNL_ADDR2 = '0,
    parameter logic [7:0] UNL_DATA1 = 8'h00,
    parameter logic [7:0] UNL_DATA2 = 8'h00
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Flash pins.
    output logic [ADDR_W-1:0] flashAddr,
    output logic [DQ_W-1:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [DQ_W-1:0] flashDqIn,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic flashRstN,
    output logic highVoltageLevel
);
    nes_st_t st_r, st_nxt;
    nes_op_t op_r, op_nxt, opIn;
    logic byp_r, byp_nxt, done_r, done_nxt, fail_r, fail_nxt;
    logic timer_r, timer_nxt, win_r, win_nxt, susp_r, susp_nxt;
    logic vhh_r, vhh_nxt, unprot_r, unprot_nxt, refused_r, refused_nxt;
    logic [2:0] idx_r, idx_nxt, wrCnt_r, wrCnt_nxt;
    logic [ADDR_W-1:0] blk_r, blk_nxt;
    logic [DQ_W-1:0] pollA_r, pollA_nxt, pollB_r, pollB_nxt;
    logic [31:0] pollCnt_r, pollCnt_nxt, rdata_r, rdata_nxt;
    logic [7:0] rstCnt_r, rstCnt_nxt;
    logic [10:0] step;
    logic busStart, busWrite, busDone, ctrlWr, accept, seqEnd;
    logic [ADDR_W-1:0] busAddr;
    logic [DQ_W-1:0] busRd;

    // Step of a command sequence: {valid, address select, data}.
    // Address select: 0 any, 1 first unlock, 2 second unlock, 3 block.
    function automatic logic [10:0] stepOf(input nes_op_t op,
        input logic byp, input logic [2:0] i);
        logic chip;
        chip = (op == `NES_OP_CHIP);
        stepOf = 11'h000;
        case (op)
            `NES_OP_CHIP, `NES_OP_BLOCK:
            begin
                if (byp) // RULE13 RULE22
                begin
                    if (i == 3'd0)
                        stepOf = {3'b100, `NES_CMD_SETUP};
                    else if (i == 3'd1)
                        stepOf = chip ? {3'b100, `NES_CMD_CHIP} :
                            {3'b111, `NES_CMD_BLOCK};
                end
                else // RULE7 RULE14
                begin
                    case (i)
                        3'd0, 3'd3: stepOf = {3'b101, UNL_DATA1};
                        3'd1, 3'd4: stepOf = {3'b110, UNL_DATA2};
                        3'd2: stepOf = {3'b101, `NES_CMD_SETUP};
                        3'd5: stepOf = chip ? {3'b101, `NES_CMD_CHIP} :
                            {3'b111, `NES_CMD_BLOCK};
                        default: stepOf = 11'h000;
                    endcase
                end
            end
            `NES_OP_ADD: // RULE14 RULE22
                stepOf = (i == 3'd0) ? {3'b111, `NES_CMD_BLOCK} : 11'h000;
            `NES_OP_SUSP: // RULE23
                stepOf = (i == 3'd0) ? {3'b100, `NES_CMD_SUSP} : 11'h000;
            `NES_OP_RESUME: // RULE1
                stepOf = (i == 3'd0) ? {3'b100, `NES_CMD_RESUME} : 11'h000;
            `NES_OP_RDRST:
                stepOf = (i == 3'd0) ? {3'b100, `NES_CMD_RDRST} : 11'h000;
            default:
                stepOf = 11'h000;
        endcase
    endfunction

    assign step = stepOf(op_r, byp_r, idx_r);
    assign ctrlWr = regWr && (regAddr == `NES_REG_CTRL);
    assign opIn = regWdata[3:0];
    assign seqEnd = (st_r == ST_SEQ) && !step[10];
    // A resume without a suspend, or a block added outside the window,
    // is refused here rather than left for the device to ignore.
    assign accept = (opIn >= `NES_OP_CHIP) && (opIn <= `NES_OP_POLL) &&
        !((opIn == `NES_OP_ADD) && !win_r) && // RULE14
        !((opIn == `NES_OP_RESUME) && !susp_r); // RULE2
    always_comb
    begin
        case (step[9:8])
            2'd1: busAddr = UNL_ADDR1;
            2'd2: busAddr = UNL_ADDR2;
            2'd3: busAddr = blk_r;
            default: busAddr = '0;
        endcase
    end
    assign busStart = (st_r == ST_SEQ && step[10]) || st_r == ST_CHK ||
        st_r == ST_P1 || st_r == ST_P2;
    assign busWrite = (st_r == ST_SEQ);

    // ==========================================
    // Sequencer.
    always_comb
    begin
        st_nxt = st_r;
        op_nxt = op_r;
        byp_nxt = byp_r;
        idx_nxt = idx_r;
        wrCnt_nxt = wrCnt_r;
        blk_nxt = blk_r;
        done_nxt = done_r;
        fail_nxt = fail_r;
        timer_nxt = timer_r;
        win_nxt = win_r;
        susp_nxt = susp_r;
        vhh_nxt = vhh_r;
        unprot_nxt = unprot_r;
        refused_nxt = refused_r;
        pollA_nxt = pollA_r;
        pollB_nxt = pollB_r;
        pollCnt_nxt = pollCnt_r;
        rstCnt_nxt = rstCnt_r;
        rdata_nxt = 32'h0000_0000;
        if (regWr && regAddr == `NES_REG_ADDR)
            blk_nxt = regWdata[ADDR_W-1:0];
        if (ctrlWr && regWdata[`NES_CTL_UNPROT])
            unprot_nxt = 1'b1;
        if (ctrlWr && regWdata[`NES_CTL_VHH_OFF])
            vhh_nxt = 1'b0;
        else if (ctrlWr && regWdata[`NES_CTL_VHH_ON] && unprot_r)
            vhh_nxt = 1'b1; // RULE6
        case (st_r)
            ST_IDLE:
            begin
                if (ctrlWr && opIn != `NES_OP_NONE)
                begin
                    refused_nxt = !accept;
                    if (accept)
                    begin
                        op_nxt = opIn;
                        // Under high voltage the device is in bypass.
                        byp_nxt = regWdata[`NES_CTL_BYP] | vhh_r; // RULE4
                        idx_nxt = 3'd0;
                        wrCnt_nxt = 3'd0;
                        done_nxt = 1'b0;
                        fail_nxt = 1'b0;
                        pollCnt_nxt = 32'h0000_0000;
                        if (opIn != `NES_OP_ADD && opIn != `NES_OP_SUSP)
                            win_nxt = 1'b0; // RULE16
                        if (opIn == `NES_OP_HWRST)
                        begin
                            rstCnt_nxt = 8'(`NES_RST_CYC);
                            st_nxt = ST_HWR;
                        end
                        else if (opIn == `NES_OP_POLL)
                            st_nxt = ST_P1;
                        else
                            st_nxt = ST_SEQ;
                    end
                end
            end
            ST_SEQ:
            begin
                if (step[10])
                    st_nxt = ST_SEQW;
                else if (op_r == `NES_OP_CHIP || op_r == `NES_OP_RESUME)
                    st_nxt = ST_P1; // RULE3
                else if (op_r == `NES_OP_BLOCK || op_r == `NES_OP_ADD)
                    st_nxt = ST_CHK; // RULE15
                else
                begin
                    if (op_r == `NES_OP_SUSP)
                    begin
                        susp_nxt = 1'b1; // RULE23
                        win_nxt = 1'b0; // RULE24
                    end
                    done_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
                if (!step[10] && op_r == `NES_OP_RESUME)
                    susp_nxt = 1'b0; // RULE1
            end
            ST_SEQW:
            begin
                if (busDone)
                begin
                    idx_nxt = idx_r + 3'd1;
                    wrCnt_nxt = wrCnt_r + 3'd1;
                    st_nxt = ST_SEQ;
                end
            end
            ST_CHK:
                st_nxt = ST_CHKW;
            ST_CHKW:
            begin
                if (busDone)
                begin
                    // Adds stay open only while the timer is running.
                    timer_nxt = busRd[`NES_BIT_TIMER]; // RULE17
                    win_nxt = !busRd[`NES_BIT_TIMER]; // RULE18
                    pollA_nxt = busRd;
                    st_nxt = ST_IDLE;
                end
            end
            ST_P1:
                st_nxt = ST_P1W;
            ST_P1W:
            begin
                if (busDone)
                begin
                    pollA_nxt = busRd;
                    st_nxt = ST_P2;
                end
            end
            ST_P2:
                st_nxt = ST_P2W;
            ST_P2W:
            begin
                if (busDone)
                begin
                    pollB_nxt = busRd;
                    timer_nxt = busRd[`NES_BIT_TIMER];
                    if (pollA_r[`NES_BIT_TOGGLE] == busRd[`NES_BIT_TOGGLE])
                    begin
                        done_nxt = 1'b1; // RULE3
                        win_nxt = 1'b0;
                        vhh_nxt = 1'b0; // RULE5
                        st_nxt = ST_IDLE;
                    end
                    else if (pollCnt_r >= 32'(POLL_LIMIT - 1))
                    begin
                        // A stuck device stays in polling; reset it.
                        fail_nxt = 1'b1; // RULE10
                        op_nxt = `NES_OP_RDRST;
                        idx_nxt = 3'd0;
                        wrCnt_nxt = 3'd0;
                        st_nxt = ST_SEQ;
                    end
                    else
                    begin
                        pollCnt_nxt = pollCnt_r + 32'h0000_0001;
                        st_nxt = ST_P1;
                    end
                end
            end
            ST_HWR:
            begin
                rstCnt_nxt = rstCnt_r - 8'h01;
                if (rstCnt_r == 8'h01)
                begin
                    win_nxt = 1'b0;
                    susp_nxt = 1'b0;
                    done_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
            end
            default:
                st_nxt = ST_IDLE;
        endcase
        if (regRd)
        begin
            case (regAddr)
                `NES_REG_ADDR: rdata_nxt = 32'(blk_r);
                `NES_REG_STAT: rdata_nxt = {23'h00_0000, byp_r, refused_r,
                    vhh_r, susp_r, win_r, timer_r, fail_r, done_r,
                    st_r != ST_IDLE};
                `NES_REG_DATA: rdata_nxt = {pollA_r, pollB_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r <= ST_IDLE;
            op_r <= `NES_OP_NONE;
            byp_r <= 1'b0;
            idx_r <= 3'd0;
            wrCnt_r <= 3'd0;
            blk_r <= '0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            timer_r <= 1'b0;
            win_r <= 1'b0;
            susp_r <= 1'b0;
            vhh_r <= 1'b0;
            unprot_r <= 1'b0;
            refused_r <= 1'b0;
            pollA_r <= '0;
            pollB_r <= '0;
            pollCnt_r <= 32'h0000_0000;
            rstCnt_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            byp_r <= byp_nxt;
            idx_r <= idx_nxt;
            wrCnt_r <= wrCnt_nxt;
            blk_r <= blk_nxt;
            done_r <= done_nxt;
            fail_r <= fail_nxt;
            timer_r <= timer_nxt;
            win_r <= win_nxt;
            susp_r <= susp_nxt;
            vhh_r <= vhh_nxt;
            unprot_r <= unprot_nxt;
            refused_r <= refused_nxt;
            pollA_r <= pollA_nxt;
            pollB_r <= pollB_nxt;
            pollCnt_r <= pollCnt_nxt;
            rstCnt_r <= rstCnt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    nes_bus_cycle #(.ADDR_W(ADDR_W), .DQ_W(DQ_W)) u_bus (
        .ref_clk(ref_clk), .rst(rst), .start(busStart),
        .isWrite(busWrite), .addrIn(busAddr),
        .dataIn(DQ_W'(step[7:0])), .done(busDone), .readData(busRd),
        .flashAddr(flashAddr), .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
        .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN));

    assign regRdata = rdata_r;
    assign flashRstN = (st_r != ST_HWR);
    assign highVoltageLevel = vhh_r;

    // ==========================================
    // Checks.
    property p_chip6;
        @(posedge ref_clk) disable iff (rst)
        seqEnd && op_r == `NES_OP_CHIP && !byp_r |-> wrCnt_r == 3'd6;
    endproperty
    a_chip6: assert property (p_chip6) else $error("chip erase not 6"); // RULE7
    property p_chip2;
        @(posedge ref_clk) disable iff (rst)
        seqEnd && op_r == `NES_OP_CHIP && byp_r |-> wrCnt_r == 3'd2;
    endproperty
    a_chip2: assert property (p_chip2) else $error("bypass chip not 2"); // RULE13
    property p_blk6;
        @(posedge ref_clk) disable iff (rst)
        seqEnd && op_r == `NES_OP_BLOCK && !byp_r |=> st_r == ST_CHK
            && $past(wrCnt_r) == 3'd6;
    endproperty
    a_blk6: assert property (p_blk6) else $error("block erase not 6"); // RULE14
    property p_blk2;
        @(posedge ref_clk) disable iff (rst)
        seqEnd && byp_r && op_r == `NES_OP_BLOCK |-> wrCnt_r == 3'd2
            && blk_r == $past(blk_r);
    endproperty
    a_blk2: assert property (p_blk2) else $error("bypass block not 2"); // RULE22
    property p_susp;
        @(posedge ref_clk) disable iff (rst)
        busStart && busWrite && op_r == `NES_OP_SUSP |->
            step[7:0] == `NES_CMD_SUSP ##[1:40] susp_r;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend not sent"); // RULE23
    property p_resume;
        @(posedge ref_clk) disable iff (rst)
        seqEnd && op_r == `NES_OP_RESUME |=> st_r == ST_P1 && !susp_r;
    endproperty
    a_resume: assert property (p_resume) else $error("resume no poll"); // RULE1
    property p_poll;
        @(posedge ref_clk) disable iff (rst)
        st_r == ST_P2W && busDone && st_nxt == ST_IDLE |->
            pollA_r[`NES_BIT_TOGGLE] == busRd[`NES_BIT_TOGGLE];
    endproperty
    a_poll: assert property (p_poll) else $error("done while toggling"); // RULE3
    property p_fail;
        @(posedge ref_clk) disable iff (rst)
        $rose(fail_r) |-> op_r == `NES_OP_RDRST ##[0:40] busStart && busWrite;
    endproperty
    a_fail: assert property (p_fail) else $error("no reset on fail"); // RULE10
    property p_vhh;
        @(posedge ref_clk) disable iff (rst)
        $rose(vhh_r) |-> $past(unprot_r);
    endproperty
    a_vhh: assert property (p_vhh) else $error("high voltage early"); // RULE6
    property p_vhhoff;
        @(posedge ref_clk) disable iff (rst)
        st_r == ST_P2W && st_nxt == ST_IDLE |=> !vhh_r && done_r;
    endproperty
    a_vhhoff: assert property (p_vhhoff) else $error("high voltage kept"); // RULE5
endmodule // nes_host
`default_nettype wire

// file: sim/nes_flash_model.sv
`default_nettype none
module nes_flash_model (
    // Flash pins, device side.
    input wire logic [23:0] flashAddr,
    input wire logic [15:0] flashDqOut,
    input wire logic flashDqOe,
    output logic [15:0] flashDqIn,
    input wire logic flashCeN,
    input wire logic flashWeN,
    input wire logic flashOeN,
    input wire logic flashRstN,
    input wire logic highVoltageLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    int wcnt = 0;
    int rcnt = 0;
    int left = 0;
    bit stuck = 0;
    bit tgl = 0;
    logic [7:0] prevCmd = 8'h00;
    logic [15:0] last = 16'h0000;
    logic [23:0] lastAddr = 24'h00_0000;
    bit dqOff = 0;
    // A released bus shows the inverse of the last word, so a stale hold
    // can never pass for fresh read data.
    assign flashDqIn = flashOeN ? ~last : last;
    always @(negedge flashOeN)
    begin
        tgl = tgl ^ (left > 0);
        // No error bit is ever raised, as for silently skipped blocks.
        if (left > 0)
            last = {9'h000, tgl, 6'h00};
        else
            last = 16'hFFFF;
        if (left > 0 && !stuck)
            left--;
    end
    always @(posedge flashWeN)
    begin
        if (!flashCeN && flashRstN)
        begin
            wcnt++;
            lastAddr = flashAddr;
            dqOff = dqOff | !flashDqOe;
            case (flashDqOut[7:0])
                8'h10: left = 4;
                8'h30:
                    left = (prevCmd == 8'hB0) ? 4 : 1000;
                8'hB0, 8'hF0: left = 0;
                default: ;
            endcase
            prevCmd = flashDqOut[7:0];
        end
    end
    always @(negedge flashRstN)
    begin
        rcnt++;
        left = 0;
    end
endmodule // nes_flash_model
`default_nettype wire

// file: sim/nor_erase_resume_sequencer_tb_top.sv
`default_nettype none
`define CHK(nm, e, g) \
    begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module nor_erase_resume_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, regWr = 0, regRd = 0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata, st;
    logic [23:0] fa;
    logic [15:0] dqo, dqi;
    logic oe, ce, we, re, rn, hv;
    int fail_count = 0, check_count = 0, n0;
    always #2.5 ref_clk = ~ref_clk;
    nes_host #(.POLL_LIMIT(8)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .flashAddr(fa),
        .flashDqOut(dqo), .flashDqOe(oe), .flashDqIn(dqi), .flashCeN(ce),
        .flashWeN(we), .flashOeN(re), .flashRstN(rn),
        .highVoltageLevel(hv));
    nes_flash_model u_fl (.flashAddr(fa), .flashDqOut(dqo), .flashDqOe(oe),
        .flashDqIn(dqi), .flashCeN(ce), .flashWeN(we), .flashOeN(re),
        .flashRstN(rn), .highVoltageLevel(hv));
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 st = regRdata;
        @(posedge ref_clk);
    endtask
    // Issues one operation and polls status until the busy bit clears, bounded.
    task automatic op(input logic [31:0] c);
        n0 = u_fl.wcnt;
        wr(4'h0, c);
        st = 32'h1;
        for (int i = 0; i < 1000 && st[0] !== 1'b0; i++)
            rd(4'h8);
    endtask
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        fail_count++;
        end_sim();
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h8);
        `CHK("idle", 32'h0, st)
        wr(4'h0, 32'h5);
        rd(4'h8);
        `CHK("refused", 1'b1, st[7])
        op(32'h1);
        `CHK("chipWr", 6, u_fl.wcnt - n0)
        `CHK("chipCmd", 8'h10, u_fl.prevCmd)
        `CHK("chipSt", 3'b010, st[2:0])
        rd(4'hC);
        `CHK("data", 32'hFFFF_FFFF, st)
        op(32'h8);
        `CHK("poll", 3'b010, st[2:0])
        op(32'h11);
        `CHK("bypWr", 2, u_fl.wcnt - n0)
        wr(4'h4, 32'h0002_0000);
        op(32'h2);
        `CHK("blkWr", 6, u_fl.wcnt - n0)
        `CHK("blkWin", 2'b10, st[4:3])
        `CHK("blkAdr", 24'h02_0000, u_fl.lastAddr)
        op(32'h3);
        `CHK("addWr", 1, u_fl.wcnt - n0)
        op(32'h12);
        `CHK("bypBlk", 2, u_fl.wcnt - n0)
        op(32'h4);
        `CHK("susp", 9'h1B0, {st[5], u_fl.prevCmd})
        wr(4'h0, 32'h3);
        rd(4'h8);
        `CHK("addLate", 1'b1, st[7])
        op(32'h5);
        `CHK("resume", 12'h230, {st[5], st[2:0], u_fl.prevCmd})
        op(32'h6);
        `CHK("rdrst", 8'hF0, u_fl.prevCmd)
        u_fl.stuck = 1'b1;
        op(32'h1);
        `CHK("fail", 9'h1F0, {st[2], u_fl.prevCmd})
        u_fl.stuck = 1'b0;
        op(32'h7);
        `CHK("hwrst", 1, u_fl.rcnt)
        wr(4'h0, 32'h40);
        wr(4'h0, 32'h20);
        rd(4'h8);
        `CHK("hvOn", 2'b11, {st[6], hv})
        op(32'h1);
        `CHK("hvWr", 2, u_fl.wcnt - n0)
        `CHK("hvOff", 1'b0, hv)
        `CHK("dqOe", 1'b0, u_fl.dqOff)
        end_sim();
    end
endmodule // nor_erase_resume_sequencer_tb_top
`default_nettype wire
